// *** design/apm_cfg.svh ***
// register map, field positions, reset values and timing counts of the aux pll and clock monitor
`ifndef APM_CFG_SVH
`define APM_CFG_SVH
`define APM_OFS_AUX1      8'h00
`define APM_OFS_AUX2      8'h04
`define APM_OFS_OSC       8'h08
`define APM_OFS_CFG       8'h0c
`define APM_OFS_STAT      8'h10
`define APM_AUX1_ENA      15
`define APM_AUX1_LOCK     14
`define APM_AUX1_PRISEL   13
`define APM_AUX1_AUX_FAST_RC_SELECT   12
`define APM_AUX1_DIVSRC   11
`define APM_AUX1_POST_HI  7
`define APM_AUX1_POST_LO  5
`define APM_AUX1_PRE_HI   2
`define APM_AUX1_PRE_LO   0
`define APM_OSC_SRC_HI    14
`define APM_OSC_SRC_LO    12
`define APM_OSC_CF        3
`define APM_OSC_SWREQ     0
`define APM_RST_CFG       2'h0
`define APM_RST_SRC       3'h0
`define APM_SRC_FRC       3'h0
`define APM_SRC_PRI       3'h2
`define APM_SRC_PRIPLL    3'h3
`define APM_SRC_SEC       3'h4
`define APM_FB_ALLONES    3'h7
`define APM_FB_BASE       5'h0f
`define APM_FB_BASE_TOP   5'h12
`define APM_CLK_MHZ       40
`define APM_LOW_POWER_RC_OSC_KHZ      32
`define APM_FAIL_WIN_US   2000
`define APM_FAIL_TICKS    ((`APM_FAIL_WIN_US * `APM_LOW_POWER_RC_OSC_KHZ) / 1000)
`define APM_START_TICKS   16
`define APM_LOCK_US       10
`define APM_LOCK_CYC      (`APM_LOCK_US * `APM_CLK_MHZ)
`define APM_RESP_OKAY     2'h0
`define APM_RESP_SLVERR   2'h2
`endif

// *** design/apm_pkg.sv ***
// types shared by the aux pll and clock monitor
package apm_pkg;
  typedef struct packed {
    logic [2:0] post;  // output divider field
    logic [2:0] pre;   // reference divider field
    logic [2:0] fb;    // feedback divider field
  } apm_div_s;
  typedef struct packed {
    logic [4:0] mult;  // feedback ratio
    logic [3:0] n1;    // input ratio
    logic [3:0] n2;    // output ratio
  } apm_ratio_s;
  typedef enum logic [1:0] {
    MON_OFF,
    MON_DELAY,
    MON_WATCH,
    MON_FAILED
  } apm_mon_e;
endpackage : apm_pkg

// *** design/apm_aux_pll_monitor.sv ***
// aux pll divider control, lock detect and fail-safe clock monitor with axi4-lite registers
//
// Summary of operation
// - input ratio N1 is the 3-bit reference divider field plus one.
// - feedback ratio M is the 3-bit feedback divider field plus fifteen.
// - feedback field all ones gives M as field plus eighteen.
// - output ratio N2 is the field at bits 7:5 plus one.
// - aux clock equals input times M over N1 times N2.
// - any input or divider change restarts a nonzero settling interval.
// - lock flag is read-only bit 14 of aux control one.
// - lock flag clears at reset and on any aux clock switch.
// - monitor active and low-power rc running only with config 00 outside sleep.
// - no system clock within window raises trap and forces fast rc.
// - on failure the current source field loads the fast rc code.
// - on failure the clock-fail flag at bit 3 sets.
// - on failure the switch request at bit 0 clears.
// - a failure in sleep does not wake the device.
// - checking starts once system clock ready and start delay elapsed.
// - start delay applies only for primary or secondary source.
// - watchdog time base keeps running on the low-power rc.
// - aux pll path is enabled only while bit 15 is set.
// - fast rc select picks fast rc, else primary select chooses reference.
// - config 1x disables switching and monitor; 01 switching only.
`timescale 1ns/100ps
`include "apm_cfg.svh"
module apm_aux_pll_monitor #(
  parameter int FAIL_TICKS  = `APM_FAIL_TICKS,  // failure window in low-power rc ticks
  parameter int START_TICKS = `APM_START_TICKS, // monitor start delay in low-power rc ticks
  parameter int LOCK_CYC    = `APM_LOCK_CYC     // lock settling interval in ref_clk cycles
) (
  input  wire logic                 ref_clk,        // 40 MHz clock
  input  wire logic                 rst_b,          // synchronous reset, active low
  input  wire logic                 s_axi_awvalid,  // write address valid
  output logic                      s_axi_awready,  // write address ready
  input  wire logic [7:0]           s_axi_awaddr,   // write address
  input  wire logic                 s_axi_wvalid,   // write data valid
  output logic                      s_axi_wready,   // write data ready
  input  wire logic [31:0]          s_axi_wdata,    // write data
  input  wire logic [3:0]           s_axi_wstrb,    // write byte strobes
  output logic                      s_axi_bvalid,   // write response valid
  input  wire logic                 s_axi_bready,   // write response ready
  output logic [1:0]                s_axi_bresp,    // write response
  input  wire logic                 s_axi_arvalid,  // read address valid
  output logic                      s_axi_arready,  // read address ready
  input  wire logic [7:0]           s_axi_araddr,   // read address
  output logic                      s_axi_rvalid,   // read data valid
  input  wire logic                 s_axi_rready,   // read data ready
  output logic [31:0]               s_axi_rdata,    // read data
  output logic [1:0]                s_axi_rresp,    // read response
  input  wire logic                 sysClkIn,       // monitored system clock pin
  input  wire logic                 lprcClkIn,      // low-power rc oscillator pin
  input  wire logic                 sysClkReady,    // system clock ready pin
  input  wire logic                 sleepIn,        // device in sleep
  input  wire logic                 fbAlignedIn,    // phase detector sees feedback aligned
  output logic                      auxPllEnable,   // aux pll and oscillator path enable
  output logic [1:0]                auxRefSel,      // 0 aux osc, 1 primary, 2 fast rc
  output logic                      auxDivSrcSel,   // aux pll feeds the aux clock divider
  output apm_pkg::apm_ratio_s       auxRatio,       // ratios to the pll core
  output logic                      clkFailTrap,    // one-cycle clock failure trap
  output logic                      forceFastRc,    // system clock forced to fast rc
  output logic                      lprcRun,        // low-power rc kept running
  output logic                      wdtTick,        // watchdog time base tick
  output logic                      clkSwitchEn     // clock switching allowed
);
  import apm_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [2:0] sysSync_ff, lprcSync_ff, rdySync_ff, fbSync_ff;
  always_ff @(posedge ref_clk) begin
    sysSync_ff  <= {sysSync_ff[1:0], sysClkIn};
    lprcSync_ff <= {lprcSync_ff[1:0], lprcClkIn};
    rdySync_ff  <= {rdySync_ff[1:0], sysClkReady};
    fbSync_ff   <= {fbSync_ff[1:0], fbAlignedIn};
  end
  // an edge shows where stages two and three differ; a level counts once both are high
  wire sysEdge  = sysSync_ff[2] ^ sysSync_ff[1];
  wire lprcTick = lprcSync_ff[1] & ~lprcSync_ff[2];
  wire sysRdy   = rdySync_ff[1] & rdySync_ff[2];
  wire fbAlign  = fbSync_ff[1] & fbSync_ff[2];

  // ==========================================================
  // axi4-lite slave
  logic        awHave_ff, wHave_ff;
  logic [7:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  wire doWrite  = awHave_ff & wHave_ff & ~s_axi_bvalid;
  wire nxt_awHave = (awHave_ff | (s_axi_awvalid & s_axi_awready)) & ~doWrite;
  wire nxt_wHave  = (wHave_ff | (s_axi_wvalid & s_axi_wready)) & ~doWrite;
  wire [15:0] wMask = {{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
  wire wrAux1 = doWrite & (awAddr_ff == `APM_OFS_AUX1);
  wire wrAux2 = doWrite & (awAddr_ff == `APM_OFS_AUX2);
  wire wrOsc  = doWrite & (awAddr_ff == `APM_OFS_OSC);
  wire wrCfg  = doWrite & (awAddr_ff == `APM_OFS_CFG);

  // register address decode, shared by both channels
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `APM_OFS_AUX1) | (a == `APM_OFS_AUX2) | (a == `APM_OFS_OSC) |
             (a == `APM_OFS_CFG) | (a == `APM_OFS_STAT);
  endfunction : mapped

  // feedback ratio from its field
  function automatic logic [4:0] fbRatio(input logic [2:0] f);
    fbRatio = (f == `APM_FB_ALLONES) ? (`APM_FB_BASE_TOP + {2'h0, f})
                                     : (`APM_FB_BASE + {2'h0, f});
  endfunction : fbRatio

  // address and data channels taken in either order
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      awHave_ff     <= 1'b0;
      wHave_ff      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awAddr_ff     <= 8'h00;
      wData_ff      <= 32'h0;
      wStrb_ff      <= 4'h0;
    end else begin
      awHave_ff     <= nxt_awHave;
      wHave_ff      <= nxt_wHave;
      s_axi_awready <= ~nxt_awHave;
      s_axi_wready  <= ~nxt_wHave;
      if (s_axi_awvalid && s_axi_awready) awAddr_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
    end
  end

  // write response
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `APM_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(awAddr_ff) ? `APM_RESP_OKAY : `APM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // control and status registers
  logic       ena_ff, priSel_ff, aux_fast_rc_select_ff, divSrc_ff, lock_ff, cf_ff, swReq_ff;
  apm_div_s   div_ff;
  logic [2:0] curSrc_ff;
  logic [1:0] cfg_ff;
  apm_mon_e   mon_ff;
  wire [15:0] aux1Word = {ena_ff, lock_ff, priSel_ff, aux_fast_rc_select_ff, divSrc_ff, 3'h0,
                          div_ff.post, 2'h0, div_ff.pre};
  wire [15:0] aux1New  = (aux1Word & ~wMask) | (wData_ff[15:0] & wMask);
  wire [15:0] oscWord  = {1'b0, curSrc_ff, 8'h00, cf_ff, 2'h0, swReq_ff};
  wire        monActive = (cfg_ff == 2'h0) & ~sleepIn;
  wire        failEv;
  // any change of source or divider is an aux clock switch
  wire auxChange = (wrAux1 & (aux1New[13:11] != {priSel_ff, aux_fast_rc_select_ff, divSrc_ff} |
                              aux1New[7:5] != div_ff.post | aux1New[2:0] != div_ff.pre)) |
                   (wrAux2 & wStrb_ff[0] & (wData_ff[2:0] != div_ff.fb));

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ena_ff    <= 1'b0;
      priSel_ff <= 1'b0;
      aux_fast_rc_select_ff <= 1'b0;
      divSrc_ff <= 1'b0;
      div_ff    <= '0;
      cfg_ff    <= `APM_RST_CFG;
    end else begin
      if (wrAux1) begin
        ena_ff    <= aux1New[`APM_AUX1_ENA];
        priSel_ff <= aux1New[`APM_AUX1_PRISEL];
        aux_fast_rc_select_ff <= aux1New[`APM_AUX1_AUX_FAST_RC_SELECT];
        divSrc_ff <= aux1New[`APM_AUX1_DIVSRC];
        div_ff.post <= aux1New[`APM_AUX1_POST_HI:`APM_AUX1_POST_LO];
        div_ff.pre  <= aux1New[`APM_AUX1_PRE_HI:`APM_AUX1_PRE_LO];
      end
      if (wrAux2 && wStrb_ff[0]) div_ff.fb <= wData_ff[2:0];
      if (wrCfg && wStrb_ff[0]) cfg_ff <= wData_ff[1:0];
    end
  end

  // oscillator control: a failure wins over a software write
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      curSrc_ff <= `APM_RST_SRC;
      cf_ff     <= 1'b0;
      swReq_ff  <= 1'b0;
    end else if (failEv) begin
      curSrc_ff <= `APM_SRC_FRC;
      cf_ff     <= 1'b1;
      swReq_ff  <= 1'b0;
    end else if (wrOsc) begin
      if (wStrb_ff[1]) curSrc_ff <= wData_ff[`APM_OSC_SRC_HI:`APM_OSC_SRC_LO];
      if (wStrb_ff[0]) begin
        cf_ff    <= wData_ff[`APM_OSC_CF];
        swReq_ff <= wData_ff[`APM_OSC_SWREQ] & (cfg_ff[1] == 1'b0);
      end
    end
  end

  // ==========================================================
  // aux pll lock detector
  logic [15:0] lockCnt_ff;
  wire lockRestart = auxChange | ~ena_ff | ~fbAlign;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lock_ff    <= 1'b0;
      lockCnt_ff <= 16'h0;
    end else if (lockRestart) begin
      lock_ff    <= 1'b0;
      lockCnt_ff <= 16'h0;
    end else if (lockCnt_ff == 16'(LOCK_CYC - 1)) begin
      lock_ff    <= 1'b1;
    end else begin
      lockCnt_ff <= lockCnt_ff + 16'h1;
    end
  end

  // ==========================================================
  // fail-safe monitor
  logic [15:0] monCnt_ff;
  wire delayApplies = (curSrc_ff == `APM_SRC_PRI) | (curSrc_ff == `APM_SRC_PRIPLL) |
                      (curSrc_ff == `APM_SRC_SEC);
  assign failEv = (mon_ff == MON_WATCH) & monActive & ~sysEdge & lprcTick &
                  (monCnt_ff == 16'(FAIL_TICKS - 1));
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mon_ff    <= MON_OFF;
      monCnt_ff <= 16'h0;
    end else if (!monActive) begin
      mon_ff    <= MON_OFF;
      monCnt_ff <= 16'h0;
    end else begin
      case (mon_ff)
        MON_OFF: begin
          monCnt_ff <= 16'h0;
          if (sysRdy && !cf_ff) mon_ff <= delayApplies ? MON_DELAY : MON_WATCH;
        end
        MON_DELAY: begin
          if (lprcTick) begin
            monCnt_ff <= monCnt_ff + 16'h1;
            if (monCnt_ff == 16'(START_TICKS - 1)) begin
              mon_ff    <= MON_WATCH;
              monCnt_ff <= 16'h0;
            end
          end
        end
        MON_WATCH: begin
          if (sysEdge) monCnt_ff <= 16'h0;
          else if (failEv) mon_ff <= MON_FAILED;
          else if (lprcTick) monCnt_ff <= monCnt_ff + 16'h1;
        end
        MON_FAILED: begin
          if (!cf_ff) mon_ff <= MON_OFF;
        end
        default: mon_ff <= MON_OFF;
      endcase
    end
  end

  // ==========================================================
  // read channel
  logic [31:0] rdWord;
  always_comb begin
    rdWord = 32'h0;
    case (s_axi_araddr)
      `APM_OFS_AUX1: rdWord = {16'h0, aux1Word};
      `APM_OFS_AUX2: rdWord = {29'h0, div_ff.fb};
      `APM_OFS_OSC:  rdWord = {16'h0, oscWord};
      `APM_OFS_CFG:  rdWord = {30'h0, cfg_ff};
      `APM_OFS_STAT: rdWord = {28'h0, lprcRun, monActive, mon_ff};
      default:       rdWord = 32'h0;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `APM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdWord;
      s_axi_rresp   <= mapped(s_axi_araddr) ? `APM_RESP_OKAY : `APM_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // registered outputs to the pll core and system
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      auxPllEnable  <= 1'b0;
      auxRefSel     <= 2'h0;
      auxDivSrcSel  <= 1'b0;
      auxRatio      <= '0;
      clkFailTrap   <= 1'b0;
      forceFastRc   <= 1'b0;
      lprcRun       <= 1'b0;
      wdtTick       <= 1'b0;
      clkSwitchEn   <= 1'b0;
    end else begin
      auxPllEnable  <= ena_ff;
      auxRefSel     <= aux_fast_rc_select_ff ? 2'h2 : {1'b0, priSel_ff};
      auxDivSrcSel  <= divSrc_ff;
      auxRatio.n1   <= {1'b0, div_ff.pre} + 4'h1;
      auxRatio.n2   <= {1'b0, div_ff.post} + 4'h1;
      auxRatio.mult <= fbRatio(div_ff.fb);
      clkFailTrap   <= failEv;
      forceFastRc   <= failEv | (forceFastRc & cf_ff);
      lprcRun       <= monActive;
      wdtTick       <= lprcTick;
      clkSwitchEn   <= ~cfg_ff[1];
    end
  end
endmodule : apm_aux_pll_monitor

// *** verif/apm_checker.sv ***
// port assertions for the aux pll and clock monitor
`timescale 1ns/100ps
module apm_checker #(
  parameter int FAIL_TICKS  = 4, // failure window ticks
  parameter int START_TICKS = 2, // start delay ticks
  parameter int LOCK_CYC    = 8  // lock settling cycles
) (
  input wire logic                ref_clk,       // clock
  input wire logic                rst_b,         // reset, active low
  input wire logic                s_axi_arvalid, // read address valid
  input wire logic                s_axi_arready, // read address ready
  input wire logic                s_axi_rvalid,  // read data valid
  input wire logic                sleepIn,       // sleep
  input wire apm_pkg::apm_ratio_s auxRatio,      // ratios
  input wire logic [1:0]          auxRefSel,     // reference select
  input wire logic                clkFailTrap,   // failure trap
  input wire logic                forceFastRc,   // forced fast rc
  input wire logic                lprcRun,       // low-power rc run
  input wire logic                wdtTick,       // watchdog tick
  input wire logic                clkSwitchEn    // switching allowed
);
  import apm_pkg::*;
  // ==========================================================
  // cycles since reset release, saturating at three
  logic [1:0] upCnt_ff;
  logic [1:0] nxt_upCnt;
  assign nxt_upCnt = (upCnt_ff == 2'h3) ? upCnt_ff : upCnt_ff + 2'h1;
  always_ff @(posedge ref_clk) begin
    upCnt_ff <= rst_b ? nxt_upCnt : 2'h0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ratio encodings, reference select, monitor outputs and read latency
  ratio_range_a: assert property ((upCnt_ff == 2'h3) |-> (auxRatio.mult inside {[5'h0f:5'h15], 5'h19}) &&
    (auxRatio.n1 inside {[4'h1:4'h8]}) && (auxRatio.n2 inside {[4'h1:4'h8]})) else $error("ratio out of range");
  ref_sel_a: assert property (auxRefSel != 2'h3) else $error("bad reference select");
  trap_pulse_a: assert property (clkFailTrap |=> !clkFailTrap) else $error("trap longer than one cycle");
  trap_force_a: assert property (clkFailTrap |-> forceFastRc) else $error("trap without fast rc");
  trap_active_a: assert property (clkFailTrap |-> $past(lprcRun)) else $error("trap while monitor off");
  sleep_stop_a: assert property (sleepIn |=> !lprcRun) else $error("low-power rc kept in sleep");
  run_cfg_a: assert property (lprcRun |-> clkSwitchEn) else $error("monitor without switching");
  wdt_pulse_a: assert property (wdtTick |=> !wdtTick) else $error("watchdog tick too long");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
  cover property (clkFailTrap);
  cover property (wdtTick && forceFastRc);
  cover property ($fell(lprcRun));
  cover property (auxRatio.mult == 5'h19);
endmodule : apm_checker
bind apm_aux_pll_monitor apm_checker #(.FAIL_TICKS(FAIL_TICKS), .START_TICKS(START_TICKS),
  .LOCK_CYC(LOCK_CYC)) apm_checker_i (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .sleepIn(sleepIn), .auxRatio(auxRatio),
  .auxRefSel(auxRefSel), .clkFailTrap(clkFailTrap), .forceFastRc(forceFastRc), .lprcRun(lprcRun),
  .wdtTick(wdtTick), .clkSwitchEn(clkSwitchEn));

// *** verif/apm_partner.sv ***
// oscillator and pll core model beside the aux pll and clock monitor
`timescale 1ns/100ps
module apm_partner (
  input  wire logic runSys,      // system oscillator running
  input  wire logic pllOn,       // aux pll path enabled
  input  wire logic slipIn,      // force loss of alignment
  output logic      sysClkIn,    // system clock
  output logic      lprcClkIn,   // low-power rc, 1 us period
  output logic      fbAlignedIn  // feedback aligned
);
  // ==========================================================
  // system clock stops at its level when the oscillator fails
  initial begin
    sysClkIn = 1'b0;
    lprcClkIn = 1'b0;
    fork
      forever #80 sysClkIn = runSys ? ~sysClkIn : sysClkIn;
      forever #500 lprcClkIn = ~lprcClkIn;
    join
  end
  // core needs 300 ns to align after enable
  always @(pllOn or slipIn) begin
    fbAlignedIn <= #300 (pllOn & ~slipIn);
  end
endmodule : apm_partner

// *** verif/apm_aux_pll_monitor_tb.sv ***
// self-checking bench for the aux pll and clock monitor
`timescale 1ns/100ps
`include "apm_cfg.svh"
module apm_aux_pll_monitor_tb;
  import apm_pkg::*;
  // ==========================================================
  // signals
  logic ref_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sysClkIn, lprcClkIn, sysClkReady, sleepIn;
  logic fbAlignedIn, auxPllEnable, auxDivSrcSel, clkFailTrap, forceFastRc, lprcRun, wdtTick, clkSwitchEn;
  logic runSys, slipIn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, auxRefSel;
  apm_ratio_s  auxRatio;
  apm_div_s    div;
  logic [2:0]  sel;
  int n_fail, checks, trapCnt, tickCnt, cycCnt, nTrap, nTick, waited, rnd;
  apm_aux_pll_monitor #(.FAIL_TICKS(4), .START_TICKS(2), .LOCK_CYC(8)) apm_aux_pll_monitor_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .sysClkIn(sysClkIn), .lprcClkIn(lprcClkIn), .sysClkReady(sysClkReady), .sleepIn(sleepIn),
    .fbAlignedIn(fbAlignedIn), .auxPllEnable(auxPllEnable), .auxRefSel(auxRefSel),
    .auxDivSrcSel(auxDivSrcSel), .auxRatio(auxRatio), .clkFailTrap(clkFailTrap),
    .forceFastRc(forceFastRc), .lprcRun(lprcRun), .wdtTick(wdtTick), .clkSwitchEn(clkSwitchEn));
  apm_partner apm_partner_i (.runSys(runSys), .pllOn(auxPllEnable), .slipIn(slipIn), .sysClkIn(sysClkIn),
    .lprcClkIn(lprcClkIn), .fbAlignedIn(fbAlignedIn));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // event counters and hang limit
  always @(posedge ref_clk) begin
    trapCnt += (clkFailTrap === 1'b1);
    tickCnt += (wdtTick === 1'b1);
    cycCnt++;
    if (cycCnt == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] expR);
    logic awOk, wOk;
    awOk = 1'b0;
    wOk = 1'b0;
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (!(awOk && wOk)) begin
      @(posedge ref_clk);
      if (!awOk && s_axi_awready === 1'b1) begin
        awOk = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wOk && s_axi_wready === 1'b1) begin
        wOk = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(expR));
  endtask : wr
  // axi4-lite read with data and response compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] expR);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check(32'(s_axi_rresp), 32'(expR));
  endtask : rd_chk
  function automatic logic [31:0] aux1_word(input logic en, input logic [2:0] s, input apm_div_s d);
    return {16'h0, en, 1'b0, s, 3'h0, d.post, 2'h0, d.pre};
  endfunction : aux1_word
  function automatic logic [31:0] exp_ratio(input apm_div_s d);
    apm_ratio_s r;
    r.mult = (d.fb == 3'h7) ? 5'(d.fb) + 5'h12 : 5'(d.fb) + 5'h0f;
    r.n1 = 4'(d.pre) + 4'h1;
    r.n2 = 4'(d.post) + 4'h1;
    return 32'(r);
  endfunction : exp_ratio
  task automatic idle(input int n, input logic stopSys);
    nTrap = trapCnt;
    runSys <= ~stopSys;
    repeat (n) @(posedge ref_clk);
    runSys <= 1'b1;
  endtask : idle
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleepIn, slipIn, rst_b} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    sysClkReady = 1'b1;
    runSys = 1'b1;
    rnd = $urandom(46);
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) rd_chk(8'(i * 4), 32'h0, `APM_RESP_OKAY);
    rd_chk(8'h20, 32'h0, `APM_RESP_SLVERR);
    wr(8'h20, 32'hffff, `APM_RESP_SLVERR);
    for (int i = 0; i < 10; i++) begin
      div = (i == 0) ? 9'h1ff : (i == 1) ? 9'h0 : 9'($urandom);
      sel = 3'($urandom);
      wr(`APM_OFS_AUX2, 32'(div.fb), `APM_RESP_OKAY);
      wr(`APM_OFS_AUX1, aux1_word(1'b0, sel, div), `APM_RESP_OKAY);
      repeat (2) @(posedge ref_clk);
      check(32'(auxRatio), exp_ratio(div));
      check(32'(auxRefSel), sel[1] ? 32'h2 : 32'(sel[2]));
      check(32'({auxDivSrcSel, auxPllEnable}), {sel[0], 1'b0});
    end
    div = '{post: 3'h1, pre: 3'h1, fb: 3'h7};
    wr(`APM_OFS_AUX1, 32'h0, `APM_RESP_OKAY);
    wr(`APM_OFS_AUX1, 32'h0800, `APM_RESP_OKAY);
    wr(`APM_OFS_AUX2, 32'(div.fb), `APM_RESP_OKAY);
    wr(`APM_OFS_AUX1, aux1_word(1'b0, 3'h1, div), `APM_RESP_OKAY);
    wr(`APM_OFS_AUX1, aux1_word(1'b1, 3'h1, div), `APM_RESP_OKAY);
    repeat (40) @(posedge ref_clk);
    rd_chk(`APM_OFS_AUX1, aux1_word(1'b1, 3'h1, div) | 32'h4000, `APM_RESP_OKAY);
    wr(`APM_OFS_AUX1, aux1_word(1'b1, 3'h5, div), `APM_RESP_OKAY);
    rd_chk(`APM_OFS_AUX1, aux1_word(1'b1, 3'h5, div), `APM_RESP_OKAY);
    check(32'(auxRefSel), 32'h1);
    repeat (40) @(posedge ref_clk);
    slipIn <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rd_chk(`APM_OFS_AUX1, aux1_word(1'b1, 3'h5, div), `APM_RESP_OKAY);
    slipIn <= 1'b0;
    wr(`APM_OFS_AUX1, 32'h4000, `APM_RESP_OKAY);
    repeat (40) @(posedge ref_clk);
    rd_chk(`APM_OFS_AUX1, 32'h0, `APM_RESP_OKAY);
    wr(`APM_OFS_OSC, 32'h2001, `APM_RESP_OKAY);
    rd_chk(`APM_OFS_OSC, 32'h2001, `APM_RESP_OKAY);
    nTick = tickCnt;
    waited = 0;
    runSys <= 1'b0;
    while (clkFailTrap !== 1'b1 && waited < 600) begin
      @(posedge ref_clk);
      waited++;
    end
    check(32'({clkFailTrap, forceFastRc}), 32'h3);
    check(32'(waited >= 3 * 40 && waited < 8 * 40), 32'h1);
    check(32'(tickCnt > nTick), 32'h1);
    rd_chk(`APM_OFS_OSC, 32'h8, `APM_RESP_OKAY);
    runSys <= 1'b1;
    wr(`APM_OFS_OSC, 32'h2000, `APM_RESP_OKAY);
    rd_chk(`APM_OFS_STAT, 32'hd, `APM_RESP_OKAY);
    rd_chk(`APM_OFS_OSC, 32'h2000, `APM_RESP_OKAY);
    check(32'(forceFastRc), 32'h0);
    sleepIn <= 1'b1;
    idle(600, 1'b1);
    check(32'({trapCnt == nTrap, lprcRun}), 32'h2);
    sleepIn <= 1'b0;
    sysClkReady <= 1'b0;
    for (int c = 3; c >= 0; c--) begin
      wr(`APM_OFS_CFG, 32'(c), `APM_RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      check(32'({clkSwitchEn, lprcRun}), {!c[1], c == 0});
      if (c < 2) idle(600, 1'b1);
      if (c < 2) check(32'(trapCnt == nTrap), 32'h1);
    end
    end_of_test();
  end
endmodule : apm_aux_pll_monitor_tb
